// *** srs_pkg.sv ***
package srs_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned SRS_REF_W = 16;
  localparam int unsigned SRS_CMD_W = 16;

  // ---------------------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SRS_MIN_CLAMP_RST  = 16'h0000;  // 0.0 rpm, 0.1 rpm units
  localparam logic [15:0] SRS_MAX_CLAMP_RST  = 16'h2710;  // 1000.0 rpm, 0.1 rpm units
  localparam logic [15:0] SRS_ACCEL_RST      = 16'h01F4;  // 5.00 s, 0.01 s units
  localparam logic [15:0] SRS_DECEL_RST      = 16'h01F4;  // 5.00 s, 0.01 s units
  localparam logic [2:0]  SRS_SEL_CODE_RST   = 3'h0;
  localparam logic [2:0]  SRS_SEL_CODE_MAX   = 3'h6;
  localparam logic [2:0]  SRS_COPY_AUTO      = 3'h3;
  localparam logic [2:0]  SRS_COPY_BOOT      = 3'h4;
  localparam logic [2:0]  SRS_COPY_READ      = 3'h1;
  localparam logic [2:0]  SRS_COPY_PROG      = 3'h2;
  localparam logic [2:0]  SRS_COPY_NONE      = 3'h0;
  localparam logic [2:0]  SRS_PRESET_ANALOG  = 3'h0;  // preset selector value 1, zero based
  localparam logic [2:0]  SRS_IDX_NO_BITS    = 3'h1;  // source index with no select bit set
  localparam logic [15:0] SRS_CMD_NONE       = 16'h0000;

  // ---------------------------------------------------------------------------
  // register map, word index times four
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SRS_A_MIN_CLAMP  = 8'h00;
  localparam logic [7:0] SRS_A_MAX_CLAMP  = 8'h04;
  localparam logic [7:0] SRS_A_ACCEL      = 8'h08;
  localparam logic [7:0] SRS_A_DECEL      = 8'h0C;
  localparam logic [7:0] SRS_A_SEL_CODE   = 8'h10;
  localparam logic [7:0] SRS_A_PRESET_SEL = 8'h14;
  localparam logic [7:0] SRS_A_CMD        = 8'h18;
  localparam logic [7:0] SRS_A_COPY       = 8'h1C;
  localparam logic [7:0] SRS_A_STATUS     = 8'h20;
  localparam logic [7:0] SRS_A_IRQ_STAT   = 8'h24;
  localparam logic [7:0] SRS_A_IRQ_EN     = 8'h28;
  localparam logic [7:0] SRS_A_IRQ_CLR    = 8'h2C;
  localparam logic [7:0] SRS_A_PRESET0    = 8'h40;

  localparam int unsigned SRS_IRQ_W = 3;  // bit0 done, bit1 refused, bit2 trip

  typedef enum logic [1:0] {
    SRS_ACT_IDLE = 2'b00,
    SRS_ACT_BUSY = 2'b01
  } srs_act_state_t;

  typedef struct packed {
    logic        start;   // one-cycle drive reset request
    logic        enabled; // drive enabled, action cannot start
    logic        done;    // action completed ok
    logic        fail;    // action failed after start
    logic        save;    // a parameter save occurred
  } srs_action_t;

endpackage

// *** srs_speed_ref.sv ***
`timescale 1ns/1ps
// Contract
// RULE1: clear command on successful reset-started action
// RULE2: action cannot start: keep command, no trip
// RULE3: started action fails: trip, keep command
// RULE4: success clears command; copy mode if below 3
// RULE5: copy 1/2 with valid command: command only, zero both
// RULE6: copy 3/4 writes card on every save
// RULE7: clamp between min and max; jog ignores min
// RULE8: max clamp bounds both directions, default 1000
// RULE9: accel setting is time per max speed
// RULE10: decel setting is time per max speed
// RULE11: code 0 uses terminals, 1-6 direct
// RULE12: no bits gives 1; bits give 2-6
// RULE13: lowest-numbered select bit wins
// RULE14: index 1/2 analog if preset 1, else preset
// RULE15: 4 keypad, 5 precision, 6 keypad only
// RULE16: keypad-only: keypad sequencing, jog disabled
// RULE17: selection re-evaluated every update cycle
module srs_speed_ref (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rstn_in,
  input  wire logic                            ce_in,
  input  wire logic [7:0]                      addr_in,
  input  wire logic [31:0]                     wdata_in,
  input  wire logic                            wr_in,
  input  wire logic                            rd_in,
  input  wire logic [4:0]                      sel_bits_in,
  input  wire logic [srs_pkg::SRS_REF_W-1:0]   analog1_in,
  input  wire logic [srs_pkg::SRS_REF_W-1:0]   analog2_in,
  input  wire logic [srs_pkg::SRS_REF_W-1:0]   keypad_ref_in,
  input  wire logic [srs_pkg::SRS_REF_W-1:0]   prec_coarse_in,
  input  wire logic [srs_pkg::SRS_REF_W-1:0]   prec_fine_in,
  input  wire logic                            jog_in,
  input  wire logic                            reverse_in,
  input  wire logic [4:0]                      seq_bits_in,
  input  wire logic [4:0]                      keypad_keys_in,
  input  wire srs_pkg::srs_action_t            action_in,
  output logic [31:0]                          rdata_out,
  output logic [srs_pkg::SRS_REF_W-1:0]        ref_mag_out,
  output logic                                 ref_rev_out,
  output logic [2:0]                           src_index_out,
  output logic [4:0]                           seq_out,
  output logic                                 jog_en_out,
  output logic [15:0]                          accel_time_out,
  output logic [15:0]                          decel_time_out,
  output logic                                 action_go_out,
  output logic                                 card_write_out,
  output logic                                 trip_out,
  output logic                                 irq_out
);
  import srs_pkg::*;

  // ---------------------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------------------
  logic [4:0]  sel_s1_reg, sel_s2_reg, seq_s1_reg, seq_s2_reg, key_s1_reg, key_s2_reg;
  logic [1:0]  jr_s1_reg, jr_s2_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_s1_reg <= 5'h00;
      sel_s2_reg <= 5'h00;
      seq_s1_reg <= 5'h00;
      seq_s2_reg <= 5'h00;
      key_s1_reg <= 5'h00;
      key_s2_reg <= 5'h00;
      jr_s1_reg  <= 2'h0;
      jr_s2_reg  <= 2'h0;
    end else if (ce_in) begin
      sel_s1_reg <= sel_bits_in;
      sel_s2_reg <= sel_s1_reg;
      seq_s1_reg <= seq_bits_in;
      seq_s2_reg <= seq_s1_reg;
      key_s1_reg <= keypad_keys_in;
      key_s2_reg <= key_s1_reg;
      jr_s1_reg  <= {jog_in, reverse_in};
      jr_s2_reg  <= jr_s1_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [15:0]          min_ref_clamp_reg, max_ref_clamp_reg;
  logic [15:0]          accel_time_setting_reg, decel_time_setting_reg;
  logic [2:0]           ref_selector_code_reg, preset_sel_reg;
  logic [SRS_CMD_W-1:0] cmd_reg;
  logic [2:0]           copy_mode_short_menu_reg;
  logic [15:0]          preset_reg [8];
  logic [SRS_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
  logic                 wr_cmd, wr_copy, wr_clr;
  srs_act_state_t       act_reg;

  assign wr_cmd  = ce_in && wr_in && addr_in == SRS_A_CMD;
  assign wr_copy = ce_in && wr_in && addr_in == SRS_A_COPY;
  assign wr_clr  = ce_in && wr_in && addr_in == SRS_A_IRQ_CLR;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      min_ref_clamp_reg      <= SRS_MIN_CLAMP_RST;  // RULE7
      max_ref_clamp_reg      <= SRS_MAX_CLAMP_RST;  // RULE8
      accel_time_setting_reg <= SRS_ACCEL_RST;      // RULE9
      decel_time_setting_reg <= SRS_DECEL_RST;      // RULE10
      ref_selector_code_reg  <= SRS_SEL_CODE_RST;   // RULE11
      preset_sel_reg         <= SRS_PRESET_ANALOG;
      irq_en_reg             <= '0;
      for (int i = 0; i < 8; i++) begin
        preset_reg[i] <= 16'h0000;
      end
    end else if (ce_in && wr_in) begin
      unique case (addr_in)
        SRS_A_MIN_CLAMP:  min_ref_clamp_reg      <= wdata_in[15:0];
        SRS_A_MAX_CLAMP:  max_ref_clamp_reg      <= wdata_in[15:0];
        SRS_A_ACCEL:      accel_time_setting_reg <= wdata_in[15:0];
        SRS_A_DECEL:      decel_time_setting_reg <= wdata_in[15:0];
        SRS_A_SEL_CODE: begin
          if (wdata_in[2:0] <= SRS_SEL_CODE_MAX) begin
            ref_selector_code_reg <= wdata_in[2:0];
          end
        end
        SRS_A_PRESET_SEL: preset_sel_reg <= wdata_in[2:0];
        SRS_A_IRQ_EN:     irq_en_reg     <= wdata_in[SRS_IRQ_W-1:0];
        default: begin
          if (addr_in[7:5] == SRS_A_PRESET0[7:5] && addr_in[1:0] == 2'h0) begin
            preset_reg[addr_in[4:2]] <= wdata_in[15:0];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // command and copy mode housekeeping
  // ---------------------------------------------------------------------------
  logic cmd_valid, copy_low;
  assign cmd_valid = cmd_reg != SRS_CMD_NONE;
  assign copy_low  = copy_mode_short_menu_reg < SRS_COPY_AUTO;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_reg        <= SRS_ACT_IDLE;
      action_go_out  <= 1'b0;
      trip_out       <= 1'b0;
      card_write_out <= 1'b0;
      irq_set        <= '0;
    end else if (ce_in) begin
      action_go_out  <= 1'b0;
      card_write_out <= action_in.save &&
                        (copy_mode_short_menu_reg == SRS_COPY_AUTO ||
                         copy_mode_short_menu_reg == SRS_COPY_BOOT);  // RULE6
      irq_set        <= '0;
      unique case (act_reg)
        SRS_ACT_IDLE: begin
          if (action_in.start && (cmd_valid || copy_mode_short_menu_reg != SRS_COPY_NONE)) begin
            if (action_in.enabled) begin
              irq_set[1] <= 1'b1;  // RULE2
            end else begin
              act_reg       <= SRS_ACT_BUSY;
              action_go_out <= 1'b1;
              trip_out      <= 1'b0;
            end
          end
        end
        SRS_ACT_BUSY: begin
          if (action_in.fail) begin
            act_reg    <= SRS_ACT_IDLE;
            trip_out   <= 1'b1;  // RULE3
            irq_set[2] <= 1'b1;
          end else if (action_in.done) begin
            act_reg    <= SRS_ACT_IDLE;
            irq_set[0] <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_reg                  <= SRS_CMD_NONE;
      copy_mode_short_menu_reg <= SRS_COPY_NONE;
    end else if (ce_in) begin
      if (act_reg == SRS_ACT_BUSY && action_in.done && !action_in.fail) begin
        cmd_reg <= SRS_CMD_NONE;  // RULE1
        if (copy_low) begin
          copy_mode_short_menu_reg <= SRS_COPY_NONE;  // RULE4 RULE5
        end
      end else begin
        if (wr_cmd) begin
          cmd_reg <= wdata_in[SRS_CMD_W-1:0];
        end
        if (wr_copy && wdata_in[2:0] <= SRS_COPY_BOOT) begin
          copy_mode_short_menu_reg <= wdata_in[2:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_reg <= '0;
      irq_out      <= 1'b0;
    end else if (ce_in) begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? wdata_in[SRS_IRQ_W-1:0] : '0)) | irq_set;
      irq_out      <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // reference selection
  // ---------------------------------------------------------------------------
  logic [2:0]  idx;
  logic [15:0] raw_ref, lo_lim, clamped;
  logic        keypad_only;

  always_comb begin
    idx = SRS_IDX_NO_BITS;  // RULE12
    if (ref_selector_code_reg != SRS_SEL_CODE_RST) begin
      idx = ref_selector_code_reg;  // RULE11
    end else begin
      for (int b = 4; b >= 0; b--) begin
        if (sel_s2_reg[b]) begin
          idx = 3'(b + 2);  // RULE13
        end
      end
    end
  end

  always_comb begin
    unique case (idx)
      3'h1:    raw_ref = (preset_sel_reg == SRS_PRESET_ANALOG) ? analog1_in : preset_reg[preset_sel_reg];  // RULE14
      3'h2:    raw_ref = (preset_sel_reg == SRS_PRESET_ANALOG) ? analog2_in : preset_reg[preset_sel_reg];
      3'h4:    raw_ref = keypad_ref_in;  // RULE15
      3'h5:    raw_ref = prec_coarse_in + {8'h00, prec_fine_in[15:8]};
      3'h6:    raw_ref = keypad_ref_in;
      default: raw_ref = preset_reg[preset_sel_reg];
    endcase
  end

  assign keypad_only = idx == 3'h6;
  assign lo_lim  = jr_s2_reg[1] && !keypad_only ? 16'h0000 : min_ref_clamp_reg;  // RULE7
  assign clamped = raw_ref > max_ref_clamp_reg ? max_ref_clamp_reg :
                   (raw_ref < lo_lim ? lo_lim : raw_ref);  // RULE8

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_mag_out    <= 16'h0000;
      ref_rev_out    <= 1'b0;
      src_index_out  <= SRS_IDX_NO_BITS;
      seq_out        <= 5'h00;
      jog_en_out     <= 1'b0;
      accel_time_out <= SRS_ACCEL_RST;
      decel_time_out <= SRS_DECEL_RST;
    end else if (ce_in) begin
      ref_mag_out    <= clamped;  // RULE17
      ref_rev_out    <= jr_s2_reg[0];
      src_index_out  <= idx;
      seq_out        <= keypad_only ? key_s2_reg : seq_s2_reg;  // RULE16
      jog_en_out     <= jr_s2_reg[1] && !keypad_only;
      accel_time_out <= accel_time_setting_reg;  // RULE9
      decel_time_out <= decel_time_setting_reg;  // RULE10
    end
  end

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        unique case (addr_in)
          SRS_A_MIN_CLAMP:  rdata_out <= {16'h0000, min_ref_clamp_reg};
          SRS_A_MAX_CLAMP:  rdata_out <= {16'h0000, max_ref_clamp_reg};
          SRS_A_ACCEL:      rdata_out <= {16'h0000, accel_time_setting_reg};
          SRS_A_DECEL:      rdata_out <= {16'h0000, decel_time_setting_reg};
          SRS_A_SEL_CODE:   rdata_out <= {29'h0, ref_selector_code_reg};
          SRS_A_PRESET_SEL: rdata_out <= {29'h0, preset_sel_reg};
          SRS_A_CMD:        rdata_out <= {16'h0000, cmd_reg};
          SRS_A_COPY:       rdata_out <= {29'h0, copy_mode_short_menu_reg};
          SRS_A_STATUS:     rdata_out <= {26'h0, trip_out, act_reg == SRS_ACT_BUSY, 1'b0, idx};
          SRS_A_IRQ_STAT:   rdata_out <= {29'h0, irq_stat_reg};
          SRS_A_IRQ_EN:     rdata_out <= {29'h0, irq_en_reg};
          default: begin
            if (addr_in[7:5] == SRS_A_PRESET0[7:5] && addr_in[1:0] == 2'h0) begin
              rdata_out <= {16'h0000, preset_reg[addr_in[4:2]]};
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_fail_trips: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE3
    ce_in && act_reg == SRS_ACT_BUSY && action_in.fail |=> trip_out && $stable(cmd_reg))
    else $error("failed action did not trip");
  chk_done_clears: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE1
    ce_in && act_reg == SRS_ACT_BUSY && action_in.done && !action_in.fail |=> cmd_reg == SRS_CMD_NONE)
    else $error("command not cleared");
  chk_refuse_keeps: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE2
    ce_in && act_reg == SRS_ACT_IDLE && action_in.start && action_in.enabled
    |=> act_reg == SRS_ACT_IDLE && trip_out == $past(trip_out))
    else $error("refused action started");
  chk_copy_high_kept: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE4
    ce_in && act_reg == SRS_ACT_BUSY && action_in.done && !copy_low |=> !copy_low)
    else $error("copy mode 3 or 4 cleared");
  chk_copy_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE5
    ce_in && act_reg == SRS_ACT_BUSY && action_in.done && !action_in.fail && copy_low
    |=> copy_mode_short_menu_reg == SRS_COPY_NONE)
    else $error("copy mode not zeroed");
  chk_card_save: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE6
    ce_in && action_in.save && copy_mode_short_menu_reg >= SRS_COPY_AUTO |=> card_write_out)
    else $error("no card write on save");
  chk_max_bound: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE8
    ce_in ##1 $stable(max_ref_clamp_reg) |-> ref_mag_out <= max_ref_clamp_reg)
    else $error("reference above max clamp");
  chk_index_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE17
    ce_in && ref_selector_code_reg == SRS_SEL_CODE_RST && sel_s2_reg[0] |=> src_index_out == 3'h2)
    else $error("index did not follow bit one");
  chk_keypad_jog: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE16
    ce_in && keypad_only |=> !jog_en_out)
    else $error("jog enabled in keypad-only");
  chk_refuse_no_go: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE2
    ce_in && act_reg == SRS_ACT_IDLE && action_in.start && action_in.enabled && !wr_cmd
    |=> !action_go_out && $stable(cmd_reg))
    else $error("refused action changed command");
  chk_term_none: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE12
    ce_in && ref_selector_code_reg == SRS_SEL_CODE_RST && sel_s2_reg == 5'h00
    |=> src_index_out == SRS_IDX_NO_BITS)
    else $error("index not one with no bits");
  chk_code_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // RULE11
    ce_in && ref_selector_code_reg != SRS_SEL_CODE_RST
    |=> src_index_out == $past(ref_selector_code_reg))
    else $error("index not equal to code");

endmodule // srs_speed_ref

// *** srs_speed_ref_tb.sv ***
`timescale 1ns/1ps
module srs_speed_ref_tb;
  import srs_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic              clk_sys_in, rstn_in, ce_in, wr_in, rd_in, jog_in, reverse_in;
  logic [7:0]        addr_in;
  logic [31:0]       wdata_in, rdata_out, rv;
  logic [4:0]        sel_bits_in, seq_bits_in, keypad_keys_in, seq_out;
  logic [15:0]       analog1_in, analog2_in, keypad_ref_in, prec_coarse_in, prec_fine_in;
  logic [15:0]       ref_mag_out, accel_time_out, decel_time_out;
  logic [2:0]        src_index_out;
  logic              ref_rev_out, jog_en_out, action_go_out, card_write_out, trip_out, irq_out;
  srs_action_t       action_in;
  int                error_cnt, tests_run;
  typedef struct { logic [2:0] code; logic [4:0] bits; logic [2:0] ps; logic [2:0] idx; logic [15:0] rf; } srs_row_t;
  srs_row_t          rows [13];

  srs_speed_ref u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sel_bits_in(sel_bits_in), .analog1_in(analog1_in),
    .analog2_in(analog2_in), .keypad_ref_in(keypad_ref_in), .prec_coarse_in(prec_coarse_in),
    .prec_fine_in(prec_fine_in), .jog_in(jog_in), .reverse_in(reverse_in), .seq_bits_in(seq_bits_in),
    .keypad_keys_in(keypad_keys_in), .action_in(action_in), .rdata_out(rdata_out), .ref_mag_out(ref_mag_out),
    .ref_rev_out(ref_rev_out), .src_index_out(src_index_out), .seq_out(seq_out), .jog_en_out(jog_en_out),
    .accel_time_out(accel_time_out), .decel_time_out(decel_time_out), .action_go_out(action_go_out),
    .card_write_out(card_write_out), .trip_out(trip_out), .irq_out(irq_out));

  // ---------------------------------------------------------------------------
  // clock and tasks
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask

  task automatic act(input srs_action_t v);
    @(posedge clk_sys_in);
    action_in <= v;
    @(posedge clk_sys_in);
    action_in <= '0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rstn_in = 1'b0; ce_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0; addr_in = '0; wdata_in = '0;
    sel_bits_in = '0; seq_bits_in = 5'h0A; keypad_keys_in = 5'h15; jog_in = 1'b1; reverse_in = 1'b0;
    analog1_in = 16'h0100; analog2_in = 16'h0200; keypad_ref_in = 16'h0300;
    prec_coarse_in = 16'h0400; prec_fine_in = 16'h1200; action_in = '0;
    error_cnt = 0; tests_run = 0;
    rows = '{'{3'h0, 5'h00, 3'h0, 3'h1, 16'h0100}, '{3'h0, 5'h00, 3'h2, 3'h1, 16'h0A02},
             '{3'h0, 5'h01, 3'h0, 3'h2, 16'h0200}, '{3'h0, 5'h06, 3'h0, 3'h3, 16'h0A00},
             '{3'h0, 5'h1C, 3'h5, 3'h4, 16'h0300}, '{3'h0, 5'h18, 3'h0, 3'h5, 16'h0412},
             '{3'h0, 5'h10, 3'h0, 3'h6, 16'h0300}, '{3'h1, 5'h10, 3'h3, 3'h1, 16'h0A03},
             '{3'h2, 5'h00, 3'h0, 3'h2, 16'h0200}, '{3'h3, 5'h00, 3'h7, 3'h3, 16'h0A07},
             '{3'h4, 5'h00, 3'h0, 3'h4, 16'h0300}, '{3'h5, 5'h01, 3'h0, 3'h5, 16'h0412},
             '{3'h6, 5'h00, 3'h1, 3'h6, 16'h0300}};
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1;
    chk("idx_rst", 32'h1, src_index_out);
    chk("accel_rst", SRS_ACCEL_RST, accel_time_out);
    chk("decel_rst", SRS_DECEL_RST, decel_time_out);
    rd(SRS_A_MIN_CLAMP); chk("min_rst", 32'h0, rv);
    rd(SRS_A_MAX_CLAMP); chk("max_rst", 32'h2710, rv);
    rd(SRS_A_SEL_CODE); chk("code_rst", 32'h0, rv);
    for (int k = 0; k < 8; k++) wr(SRS_A_PRESET0 + 8'(4 * k), 32'h0A00 + k);
    // source selection table
    foreach (rows[i]) begin
      wr(SRS_A_SEL_CODE, {29'h0, rows[i].code});
      wr(SRS_A_PRESET_SEL, {29'h0, rows[i].ps});
      sel_bits_in <= rows[i].bits;
      cyc(6);
      chk("src_index", rows[i].idx, src_index_out);
      chk("ref_mag", rows[i].rf, ref_mag_out);
      chk("jog_en", rows[i].idx != 3'h6, jog_en_out);
      chk("seq", (rows[i].idx == 3'h6) ? 5'h15 : 5'h0A, seq_out);
      rd(SRS_A_STATUS); chk("stat_idx", rows[i].idx, rv[2:0]);
    end
    // clamps
    wr(SRS_A_SEL_CODE, 32'h1); wr(SRS_A_PRESET_SEL, 32'h0); wr(SRS_A_MIN_CLAMP, 32'h0500);
    jog_in <= 1'b0;
    cyc(6); chk("ref_min", 32'h0500, ref_mag_out);
    jog_in <= 1'b1;
    cyc(6); chk("ref_jog", 32'h0100, ref_mag_out);
    analog1_in <= 16'h3000; reverse_in <= 1'b1;
    cyc(6); chk("ref_max", 32'h2710, ref_mag_out);
    chk("ref_rev", 32'h1, ref_rev_out);
    // ramp settings
    wr(SRS_A_ACCEL, 32'h0123); wr(SRS_A_DECEL, 32'h0456);
    cyc(2); chk("accel", 32'h0123, accel_time_out);
    chk("decel", 32'h0456, decel_time_out);
    rd(SRS_A_ACCEL);
    chk("accel_rd", 32'h0123, rv);
    // refused writes and unmapped read
    wr(SRS_A_SEL_CODE, 32'h7); rd(SRS_A_SEL_CODE); chk("code_ign", 32'h1, rv);
    rd(8'h30); chk("unmapped", 32'h0, rv);
    // actions
    wr(SRS_A_IRQ_EN, 32'h7); wr(SRS_A_CMD, 32'h1);
    act('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    #1 chk("go", 32'h1, action_go_out);
    rd(SRS_A_STATUS);
    chk("busy", 32'h1, rv[4]);
    cyc(1);
    chk("rd_idle", 32'h0, rdata_out);
    act('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    rd(SRS_A_CMD); chk("cmd_done", 32'h0, rv);
    rd(SRS_A_IRQ_STAT); chk("irq_done", 32'h1, rv);
    cyc(2); chk("irq_out", 32'h1, irq_out);
    wr(SRS_A_IRQ_CLR, 32'h7); cyc(3); chk("irq_clr", 32'h0, irq_out);
    wr(SRS_A_CMD, 32'h1);
    act('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0});
    #1 chk("go_ref", 32'h0, action_go_out);
    rd(SRS_A_CMD); chk("cmd_ref", 32'h1, rv);
    chk("trip_ref", 32'h0, trip_out);
    rd(SRS_A_IRQ_STAT); chk("irq_ref", 32'h2, rv);
    wr(SRS_A_IRQ_CLR, 32'h7);
    act('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    act('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    cyc(2); chk("trip", 32'h1, trip_out);
    rd(SRS_A_CMD); chk("cmd_fail", 32'h1, rv);
    rd(SRS_A_IRQ_STAT); chk("irq_trip", 32'h4, rv);
    rd(SRS_A_STATUS);
    chk("stat_trip", 32'h1, rv[5]);
    wr(SRS_A_COPY, 32'h2);
    act('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    #1 chk("trip_new", 32'h0, trip_out);
    act('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    rd(SRS_A_CMD); chk("cmd_c2", 32'h0, rv);
    rd(SRS_A_COPY); chk("copy_c2", 32'h0, rv);
    wr(SRS_A_COPY, 32'h3); wr(SRS_A_CMD, 32'h1);
    act('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    act('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    rd(SRS_A_CMD); chk("cmd_c3", 32'h0, rv);
    rd(SRS_A_COPY); chk("copy_c3", 32'h3, rv);
    act('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    #1 chk("card_c3", 32'h1, card_write_out);
    wr(SRS_A_COPY, 32'h4);
    act('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    #1 chk("card_c4", 32'h1, card_write_out);
    wr(SRS_A_COPY, 32'h5); rd(SRS_A_COPY); chk("copy_ign", 32'h4, rv);
    wr(SRS_A_COPY, 32'h0);
    act('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    #1 chk("card_c0", 32'h0, card_write_out);
    // interrupt mask
    wr(SRS_A_IRQ_EN, 32'h0); cyc(3); chk("irq_mask", 32'h0, irq_out);
    rd(SRS_A_IRQ_STAT); chk("irq_keep", 32'h1, rv[0]);
    // clock enable freeze
    ce_in <= 1'b0;
    analog1_in <= 16'h0050;
    cyc(4);
    chk("ce_hold", 32'h2710, ref_mag_out);
    wr(SRS_A_MAX_CLAMP, 32'h0100);
    ce_in <= 1'b1;
    rd(SRS_A_MAX_CLAMP);
    chk("ce_no_wr", 32'h2710, rv);
    cyc(6);
    chk("ref_follow", 32'h0050, ref_mag_out);
    // reset in mid-run
    rstn_in <= 1'b0;
    cyc(2);
    rstn_in <= 1'b1;
    #1;
    chk("idx_rst2", 32'h1, src_index_out);
    chk("trip_rst", 32'h0, trip_out);
    chk("irq_rst", 32'h0, irq_out);
    chk("rev_rst", 32'h0, ref_rev_out);
    rd(SRS_A_MAX_CLAMP);
    chk("max_rst2", 32'h2710, rv);
    rd(SRS_A_COPY);
    chk("copy_rst", 32'h0, rv);
    end_of_test();
  end
endmodule // srs_speed_ref_tb
